// ---- verilog/tsi_pkg.sv ----
`default_nettype none
package tsi_pkg;

    // Register addresses on the byte register port
    localparam logic [7:0] ADDR_OVERT     = 8'h45;
    localparam logic [7:0] ADDR_FAULT     = 8'h46;
    localparam logic [7:0] ADDR_LOW       = 8'h47;
    localparam logic [7:0] ADDR_IDEAL     = 8'h4B;
    localparam logic [7:0] ADDR_IDEAL_SEL = 8'h4C;

    // Reset values
    localparam logic [7:0] FLAGS_RST      = 8'h00;
    localparam logic [4:0] IDEAL_CODE_RST = 5'h09;
    localparam logic [6:0] IDEAL_SEL_RST  = 7'h00;
    localparam logic [7:0] READ_IDLE      = 8'h00;

    // Ideality coding: factor = 0.999 + 0.001 * code, default 1.008
    localparam int         IDEAL_W       = 5;
    localparam logic [4:0] IDEAL_DEFAULT = 5'h09;

    // Channel numbering: 0 is local, 1 to 7 are remote diodes
    localparam int         NUM_CH     = 8;
    localparam int         NUM_REMOTE = 7;
    localparam logic [2:0] LOCAL_CH   = 3'h0;
    localparam logic [2:0] LAST_CH    = 3'h7;

    // Field positions
    localparam logic [2:0] OVERT_LOCAL_BIT = 3'h7;
    localparam logic [2:0] LOW_LOCAL_BIT   = 3'h6;
    localparam logic [2:0] LOW_CH7_BIT     = 3'h7;
    localparam int         FAULT_RSVD_BIT  = 7;

    // Temperature coding and overtemperature hysteresis
    localparam int TEMP_WIDTH       = 8;
    localparam int TEMP_LSB_PER_DEG = 1;
    localparam int HYST_DEG         = 4;
    localparam int HYST_LSB         = HYST_DEG * TEMP_LSB_PER_DEG;

    // Overtemperature bit of a channel
    function automatic logic [2:0] overt_bit(input logic [2:0] ch);
        return (ch == LOCAL_CH) ? OVERT_LOCAL_BIT : ch - 3'h1;
    endfunction : overt_bit

    // Low-warning bit of a channel
    function automatic logic [2:0] low_bit(input logic [2:0] ch);
        if (ch == LOCAL_CH) begin
            return LOW_LOCAL_BIT;
        end else if (ch == LAST_CH) begin
            return LOW_CH7_BIT;
        end
        return ch - 3'h1;
    endfunction : low_bit

    // Diode fault bit of a remote channel
    function automatic logic [2:0] fault_bit(input logic [2:0] ch);
        return ch - 3'h1;
    endfunction : fault_bit

endpackage : tsi_pkg
`default_nettype wire

// ---- verilog/tsi_cmp_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface tsi_cmp_if #(parameter int TEMP_W = 8);
    logic [TEMP_W-1:0] temp;
    logic [TEMP_W-1:0] overt_lim;
    logic [TEMP_W-1:0] low_lim;
    logic              over;
    logic              under;

    // Comparator side and status side
    modport cmp  (input temp, overt_lim, low_lim, output over, under);
    modport user (output temp, overt_lim, low_lim, input over, under);
endinterface : tsi_cmp_if
`default_nettype wire

// ---- verilog/tsi_conv_cmp.sv ----
`timescale 1ns/1ns
`default_nettype none
module tsi_conv_cmp
    import tsi_pkg::*;
(
    // Comparison of one conversion result against its limits
    tsi_cmp_if.cmp c
);
    // Strict compares: equal to a limit is not out of range
    assign c.over  = c.temp > c.overt_lim;
    assign c.under = c.temp < c.low_lim;
endmodule : tsi_conv_cmp
`default_nettype wire

// ---- verilog/tsi_status_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Overtemperature bit 7 flags local above its limit; zero at reset.
// - Overtemperature bits 6..0 flag remote channels 7..1 above their limits.
// - Fault register bit 7 reads zero; bits 6..0 flag open or shorted remotes.
// - Low-warning bit 7 is remote 7, bit 6 local, bits 5..0 remotes 6..1.
// - Low-warning bit sets when temperature is below its low limit; zero at reset.
// - Ideality register keeps bits 4..0 as code; bits 7..5 ignored.
// - Unselected remote channels use default code 0x09, factor 1.008.
// - Per-remote-channel select chooses default or programmed ideality, set by host.
// - Overtemperature bit clears only once limit is 4 degrees above temperature.
// - Low-warning bits clear on read, set again by next out-of-limit conversion.
module tsi_status_regs
    import tsi_pkg::*;
#(
    parameter int TEMP_W = TEMP_WIDTH
)(
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst,
    // Byte register port
    input  wire logic [7:0]                     reg_addr,
    input  wire logic                           reg_wr,
    input  wire logic [7:0]                     reg_wdata,
    input  wire logic                           reg_rd,
    output logic      [7:0]                     reg_rdata,
    output logic                                reg_rd_ack,
    // Conversion results
    input  wire logic                           conv_done,
    input  wire logic [2:0]                     conv_chan,
    input  wire logic [TEMP_W-1:0]              conv_temp,
    input  wire logic                           conv_fault,
    // Limits per channel, index 0 local
    input  wire logic [NUM_CH-1:0][TEMP_W-1:0]  overt_limit,
    input  wire logic [NUM_CH-1:0][TEMP_W-1:0]  low_limit,
    // Ideality code in force for each channel
    output logic      [NUM_CH-1:0][IDEAL_W-1:0] ideal_code,
    // Status flag mirrors
    output logic      [7:0]                     overt_flags,
    output logic      [7:0]                     fault_flags,
    output logic      [7:0]                     low_flags
);

    // Refuse widths the compare and hysteresis cannot serve
    if (TEMP_W < 4 || TEMP_W > 16) begin : g_width_check
        $error("tsi_status_regs: TEMP_W must be 4 to 16");
    end

    // Whole state of the block
    typedef struct packed {
        logic [7:0]                     overt;
        logic [7:0]                     fault;
        logic [7:0]                     low;
        logic [IDEAL_W-1:0]             ideal;
        logic [NUM_REMOTE-1:0]          sel;
        logic [NUM_CH-1:0][TEMP_W-1:0]  last;
        logic [NUM_CH-1:0][IDEAL_W-1:0] eff;
        logic [7:0]                     rdata;
        logic                           rd_ack;
    } tsi_state_s;

    tsi_state_s st;
    tsi_state_s next_st;

    // Hysteresis at compare width
    localparam logic [TEMP_W:0] HYST = (TEMP_W+1)'(HYST_LSB);

    // Strict compares against limits live in the comparator
    tsi_cmp_if #(.TEMP_W(TEMP_W)) cmp_bus ();

    assign cmp_bus.temp      = conv_temp;
    assign cmp_bus.overt_lim = overt_limit[conv_chan];
    assign cmp_bus.low_lim   = low_limit[conv_chan];

    tsi_conv_cmp u_cmp (
        .c (cmp_bus)
    );

    // True when the limit is at least the hysteresis above a temperature
    function automatic logic released(input logic [TEMP_W-1:0] lim,
                                      input logic [TEMP_W-1:0] t);
        return {1'b0, lim} >= ({1'b0, t} + HYST);
    endfunction : released

    // Read view of each register, unmapped addresses read zero
    function automatic logic [7:0] read_view(input tsi_state_s s,
                                             input logic [7:0] a);
        if (a == ADDR_OVERT) begin
            return s.overt;
        end else if (a == ADDR_FAULT) begin
            return s.fault;
        end else if (a == ADDR_LOW) begin
            return s.low;
        end else if (a == ADDR_IDEAL) begin
            return {3'h0, s.ideal};
        end else if (a == ADDR_IDEAL_SEL) begin
            return {1'b0, s.sel};
        end
        return READ_IDLE;
    endfunction : read_view

    // Next state
    always_comb begin
        next_st = st;
        next_st.rd_ack = 1'b0;

        // Overtemperature release: a falling temperature or a raised limit both
        // show as the limit standing 4 degrees above the last reading
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (released(overt_limit[ch], st.last[ch])) begin
                next_st.overt[overt_bit(3'(ch))] = 1'b0;
            end
        end

        // Host read: capture first, then clear low warnings on success
        if (reg_rd) begin
            next_st.rdata  = read_view(st, reg_addr);
            next_st.rd_ack = 1'b1;
            if (reg_addr == ADDR_LOW) begin
                next_st.low = FLAGS_RST;
            end
        end

        // Host write: only the ideality code and its select are writable
        if (reg_wr) begin
            if (reg_addr == ADDR_IDEAL) begin
                next_st.ideal = reg_wdata[IDEAL_W-1:0];
            end else if (reg_addr == ADDR_IDEAL_SEL) begin
                next_st.sel = reg_wdata[NUM_REMOTE-1:0];
            end
        end

        // Conversion result; placed last so a set wins over a read clear
        if (conv_done) begin
            if (conv_chan != LOCAL_CH && conv_fault) begin
                // Faulted channel is skipped for temperature compares
                next_st.fault[fault_bit(conv_chan)] = 1'b1;
            end else begin
                if (conv_chan != LOCAL_CH) begin
                    next_st.fault[fault_bit(conv_chan)] = 1'b0;
                end
                next_st.last[conv_chan] = conv_temp;
                if (cmp_bus.over) begin
                    next_st.overt[overt_bit(conv_chan)] = 1'b1;
                end
                if (cmp_bus.under) begin
                    next_st.low[low_bit(conv_chan)] = 1'b1;
                end
            end
        end

        // Reserved fault bit never sets
        next_st.fault[FAULT_RSVD_BIT] = 1'b0;

        // Ideality in force per channel; local always uses the default
        next_st.eff[LOCAL_CH] = IDEAL_DEFAULT;
        for (int r = 1; r < NUM_CH; r++) begin
            next_st.eff[r] = next_st.sel[r-1] ? next_st.ideal : IDEAL_DEFAULT;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st.overt  <= FLAGS_RST;
            st.fault  <= FLAGS_RST;
            st.low    <= FLAGS_RST;
            st.ideal  <= IDEAL_CODE_RST;
            st.sel    <= IDEAL_SEL_RST;
            st.last   <= '0;
            st.eff    <= {NUM_CH{IDEAL_DEFAULT}};
            st.rdata  <= READ_IDLE;
            st.rd_ack <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign reg_rdata   = st.rdata;
    assign reg_rd_ack  = st.rd_ack;
    assign ideal_code  = st.eff;
    assign overt_flags = st.overt;
    assign fault_flags = st.fault;
    assign low_flags   = st.low;

endmodule : tsi_status_regs
`default_nettype wire

// ---- verif/tsi_status_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module tsi_status_props
    import tsi_pkg::*;
#(
    parameter int TEMP_W = 8
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_ack,
    // Conversion side
    input wire logic conv_done,
    input wire logic [2:0] conv_chan,
    input wire logic [TEMP_W-1:0] conv_temp,
    input wire logic conv_fault,
    input wire logic [7:0][TEMP_W-1:0] overt_limit,
    input wire logic [7:0][TEMP_W-1:0] low_limit,
    // Status and ideality outputs
    input wire logic [7:0][4:0] ideal_code,
    input wire logic [7:0] overt_flags,
    input wire logic [7:0] fault_flags,
    input wire logic [7:0] low_flags
);
    // One domain, so one clock and one reset serve all
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Read answers; a conversion in the read cycle would win, so it is excluded
    rd_ack_a: assert property (reg_rd |=> reg_rd_ack)
        else $error("read not answered");
    low_clr_a: assert property (reg_rd && reg_addr == ADDR_LOW && !conv_done |=> !low_flags)
        else $error("low flags kept after read");
    ideal_rd_a: assert property (reg_rd && reg_addr == ADDR_IDEAL |=> !reg_rdata[7:5])
        else $error("ideality upper bits not zero");
    fault_rsvd_a: assert property (!fault_flags[7])
        else $error("reserved fault bit set");
    // Flags follow the conversion that caused them
    overt_loc_a: assert property (conv_done && !conv_chan && conv_temp > overt_limit[0]
        |=> overt_flags[7]) else $error("local overtemperature missed");
    overt_rem_a: assert property (conv_done && conv_chan && !conv_fault
        && conv_temp > overt_limit[conv_chan] |=> overt_flags[$past(conv_chan) - 3'h1])
        else $error("remote overtemperature missed");
    low_loc_a: assert property (conv_done && !conv_chan && conv_temp < low_limit[0]
        |=> low_flags[6]) else $error("local low warning missed");
    fault_set_a: assert property (conv_done && conv_chan && conv_fault
        |=> fault_flags[$past(conv_chan) - 3'h1]) else $error("diode fault missed");
    // The local channel never takes the programmed ideality
    local_ideal_a: assert property (ideal_code[0] == IDEAL_DEFAULT)
        else $error("local ideality not default");
endmodule : tsi_status_props
bind tsi_status_regs tsi_status_props #(.TEMP_W(TEMP_W)) i_tsi_status_props (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack), .conv_done(conv_done),
    .conv_chan(conv_chan), .conv_temp(conv_temp), .conv_fault(conv_fault),
    .overt_limit(overt_limit), .low_limit(low_limit), .ideal_code(ideal_code),
    .overt_flags(overt_flags), .fault_flags(fault_flags), .low_flags(low_flags));
`default_nettype wire

// ---- verif/tsi_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module tsi_host (
    // Clock and answers
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_ack,
    // Byte requests
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    // Idle before the first request
    initial begin
        {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
    end
    // One-cycle strobe; released lines are inverted so stale values cannot pass
    task wr(logic [7:0] a, logic [7:0] v);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {~a, ~v, 1'b0};
    endtask : wr
    // A missing answer reads as unknown
    task rd(logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk);
        v = reg_rd_ack ? reg_rdata : 8'hXX;
        {reg_addr, reg_rd} = {~a, 1'b0};
    endtask : rd
endmodule : tsi_host
`default_nettype wire

// ---- verif/temp_status_ideality_regs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module temp_status_ideality_regs_tb;
    import tsi_pkg::*;
    logic clk, rst, reg_wr, reg_rd, reg_rd_ack, conv_done, conv_fault;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, overt_flags, fault_flags, low_flags, conv_temp, d;
    logic [2:0] conv_chan;
    logic [7:0][7:0] overt_limit, low_limit;
    logic [7:0][4:0] ideal_code;
    logic [31:0] r, seed = 32'h6039C76D;
    int num_errors, tests_run, ov, fl, lo, i;
    int last [8];
    tsi_status_regs i_tsi_status_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rd_ack(reg_rd_ack), .conv_done(conv_done), .conv_chan(conv_chan),
        .conv_temp(conv_temp), .conv_fault(conv_fault), .overt_limit(overt_limit),
        .low_limit(low_limit), .ideal_code(ideal_code), .overt_flags(overt_flags),
        .fault_flags(fault_flags), .low_flags(low_flags));
    tsi_host i_tsi_host (.clk(clk), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    // Xorshift source and flag positions per channel
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int ob(int c);
        return c == 0 ? 7 : c - 1;
    endfunction : ob
    function automatic int lb(int c);
        return c == 0 ? 6 : c == 7 ? 7 : c - 1;
    endfunction : lb
    task chk(logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rd(logic [7:0] a, int e);
        i_tsi_host.rd(a, d);
        chk(d, 8'(e));
    endtask : rd
    // Overtemperature clears once the limit sits 4 above the last reading
    task hyst();
        for (int k = 0; k < 8; k++)
            if (overt_limit[k] >= last[k] + 4) ov &= ~(1 << ob(k));
    endtask : hyst
    // A faulted remote reading skips the compares and keeps the old reading
    task conv(int c, int tp, bit fa);
        @(negedge clk);
        {conv_done, conv_chan, conv_temp, conv_fault} = {1'b1, 3'(c), 8'(tp), fa};
        @(negedge clk);
        conv_done = 1'b0;
        // Release against the new reading lands one edge after the conversion
        @(negedge clk);
        if (c != 0 && fa) fl |= 1 << (c - 1);
        else begin
            if (c != 0) fl &= ~(1 << (c - 1));
            last[c] = tp;
            if (tp > overt_limit[c]) ov |= 1 << ob(c);
            if (tp < low_limit[c]) lo |= 1 << lb(c);
        end
        hyst();
        chk(overt_flags, 8'(ov));
        chk(fault_flags, 8'(fl));
        chk(low_flags, 8'(lo));
    endtask : conv
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog, far beyond the roughly 1300 cycles the tests need
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
    initial begin
        {rst, conv_done, conv_chan, conv_temp, conv_fault} = 14'h2000;
        {overt_limit, low_limit} = '0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rd(ADDR_OVERT, 0);
        rd(ADDR_FAULT, 0);
        rd(ADDR_LOW, 0);
        rd(ADDR_IDEAL, 9);
        rd(ADDR_IDEAL_SEL, 0);
        rd(8'h50, 0);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            overt_limit[i] = 8'(rnd());
            low_limit[i] = 8'(rnd());
        end
        for (i = 0; i < 300; i++) begin
            r = rnd();
            conv(r[2:0], r[15:8], r[18:16] == 3'h0);
            if (r[22:20] == 3'h0) begin
                rd(ADDR_LOW, lo);
                lo = 0;
                rd(ADDR_OVERT, ov);
                rd(ADDR_FAULT, fl);
            end
        end
        $display("test random done");
        overt_limit[0] = 8'h64;
        conv(0, 200, 0);
        for (i = 3; i < 5; i++) begin
            overt_limit[0] = 8'(200 + i);
            @(negedge clk);
            hyst();
            chk(overt_flags, 8'(ov));
        end
        $display("test hysteresis done");
        for (i = 0; i < 32; i++) begin
            r = rnd();
            i_tsi_host.wr(ADDR_IDEAL, {r[7:5], 5'(i)});
            rd(ADDR_IDEAL, i);
        end
        i_tsi_host.wr(ADDR_IDEAL_SEL, 8'hC5);
        rd(ADDR_IDEAL_SEL, 8'h45);
        for (i = 0; i < 8; i++)
            chk(8'(ideal_code[i]), (i != 0 && 8'h45 >> (i - 1) & 1) ? 8'h1F : 8'h09);
        // Status registers must shrug off writes
        for (i = 0; i < 3; i++)
            i_tsi_host.wr(ADDR_OVERT + 8'(i), 8'hFF);
        rd(ADDR_OVERT, ov);
        rd(ADDR_FAULT, fl);
        rd(ADDR_LOW, lo);
        $display("test ideality done");
        end_sim();
    end
    task end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
endmodule : temp_status_ideality_regs_tb
`default_nettype wire
